// [rtl/ofb_pkg.sv]
// Constants and types shared by the offset-balance register bank.
package ofb_pkg;

  // ---------------------------------------------------------------
  // Bank layout
  // ---------------------------------------------------------------
  localparam int NUM_BANKS = 3;
  localparam int IRQ_W = 6;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [11:0] LR_BASE = 12'hF20;
  localparam logic [11:0] LEFT_OE_BASE = 12'hF40;
  localparam logic [11:0] RIGHT_OE_BASE = 12'hF60;
  localparam logic [11:0] OWN_BASE = 12'hF80;
  localparam logic [4:0] FLD_STATUS = 5'h00;
  localparam logic [4:0] FLD_ABS = 5'h01;
  localparam logic [4:0] FLD_ABS_MIN = 5'h05;
  localparam logic [4:0] FLD_ABS_MAX = 5'h09;
  localparam logic [4:0] FLD_RAW = 5'h0D;
  localparam logic [4:0] FLD_RAW_MIN = 5'h0F;
  localparam logic [4:0] FLD_RAW_MAX = 5'h11;
  localparam logic [4:0] FLD_MODE = 5'h00;
  localparam logic [4:0] FLD_IRQ_STATUS = 5'h01;
  localparam logic [4:0] FLD_IRQ_MASK = 5'h02;

  // ---------------------------------------------------------------
  // Status codes, limits and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] STATUS_NONE = 8'h00;
  localparam logic [7:0] STATUS_OK = 8'h01;
  localparam logic [7:0] STATUS_RANGE = 8'h80;
  localparam logic [2:0] BANK_PRESENT = 3'h7;
  localparam logic [15:0] RAW_MIN_8 = 16'hFFD8;
  localparam logic [15:0] RAW_MAX_8 = 16'h0028;
  localparam logic [15:0] RAW_MIN_10 = 16'hFF60;
  localparam logic [15:0] RAW_MAX_10 = 16'h00A0;
  localparam logic [31:0] ABS_MIN_8 = 32'hC1A00000;
  localparam logic [31:0] ABS_MAX_8 = 32'h41A00000;
  localparam logic [31:0] ABS_MIN_10 = 32'hC2A00000;
  localparam logic [31:0] ABS_MAX_10 = 32'h42A00000;
  localparam logic [15:0] RAW_RESET = 16'h0000;
  localparam logic MODE_RESET = 1'b0;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 6'h00;
  // Float exponent bias less one: the raw count is twice the value.
  localparam int HALF_BIAS = 126;
  // Largest exponent of a raw magnitude that fits a signed 16-bit field.
  localparam int MAX_SHIFT = 14;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic signed [15:0] right_oddeven;
    logic signed [15:0] left_oddeven;
    logic signed [15:0] lr;
  } ofb_balance_type;

  typedef struct packed {
    logic ok;
    logic [15:0] raw;
  } ofb_conv_type;

  typedef struct packed {
    logic bank_hit;
    logic own_hit;
    logic [1:0] bank;
    logic [4:0] field;
  } ofb_addr_type;

  // Byte address of a register given its block base and field index.
  function automatic logic [31:0] reg_addr(input logic [11:0] base, input logic [4:0] field);
    reg_addr = {18'h00000, 12'(base + {7'h00, field}), 2'h0};
  endfunction

endpackage

// [rtl/ofb_regs.sv]
// AHB-Lite register bank holding three pixel offset-balance settings.
//
// Operation
// - Left/right balance bank sits at register index 0x0F20.
// - Left odd/even balance bank sits at index 0x0F40, same layout.
// - Right odd/even balance bank sits at index 0x0F60, same layout.
// - Status byte at field 0x00; reads 0x00 when bank absent.
// - Status reads 0x01 when present, setting in range and the last value write accepted.
// - Status reads 0x80 while any held value is out of range.
// - Field 0x01 is a read/write IEEE single float balance value.
// - In 8-bit output mode the float spans -20 to +20, step 0.5.
// - In 10-bit output mode the float spans -80 to +80, step 0.5.
// - Fields 0x05 and 0x09 read the float minimum and maximum.
// - Field 0x0D is a signed raw setting, normally -40 to +40.
// - Applied balance equals raw setting divided by two.
// - Two-byte fields are little-endian, low byte first.
// - Fields 0x0F and 0x11 read the raw minimum and maximum.
`timescale 1ns/1ps

module ofb_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  output ofb_pkg::ofb_balance_type balance
);

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Splits a byte address into block, bank and field.
  function automatic ofb_pkg::ofb_addr_type decode(input logic [31:0] addr);
    ofb_pkg::ofb_addr_type res;
    logic [6:0] blk;
    logic aligned;
    aligned = (addr[31:14] == 18'h00000) && (addr[1:0] == 2'h0);
    blk = addr[13:7];
    res.field = addr[6:2];
    res.bank_hit = aligned && (blk >= ofb_pkg::LR_BASE[11:5])
                   && (blk <= ofb_pkg::RIGHT_OE_BASE[11:5]);
    res.own_hit = aligned && (blk == ofb_pkg::OWN_BASE[11:5]);
    res.bank = 2'(blk - ofb_pkg::LR_BASE[11:5]);
    decode = res;
  endfunction

  // Converts a float in units of pixel values to a raw half-step count.
  function automatic ofb_pkg::ofb_conv_type float_to_raw(input logic [31:0] f);
    ofb_pkg::ofb_conv_type res;
    logic [23:0] mag;
    logic [23:0] val;
    int sh;
    res.ok = 1'b0;
    res.raw = 16'h0000;
    mag = {1'b1, f[22:0]};
    sh = int'(f[30:23]) - ofb_pkg::HALF_BIAS;
    if (f[30:0] == 31'h00000000) begin
      res.ok = 1'b1;
    end else if (sh >= 0 && sh <= ofb_pkg::MAX_SHIFT) begin
      // Any fraction finer than one half step makes the value unusable.
      if ((mag & (24'hFFFFFF >> (sh + 1))) == 24'h000000) begin
        val = mag >> (23 - sh);
        res.ok = 1'b1;
        res.raw = f[31] ? 16'(24'h000000 - val) : val[15:0];
      end
    end
    float_to_raw = res;
  endfunction

  // Converts a raw half-step count back to a float; 2 raw steps per unit.
  function automatic logic [31:0] raw_to_float(input logic [15:0] r);
    logic [15:0] mag;
    logic [38:0] t;
    int p;
    mag = r[15] ? 16'(16'h0000 - r) : r;
    p = 0;
    for (int i = 0; i < 16; i++) begin
      if (mag[i]) begin
        p = i;
      end
    end
    t = {23'h000000, mag} << (23 - p);
    if (mag == 16'h0000) begin
      raw_to_float = 32'h00000000;
    end else begin
      raw_to_float = {r[15], 8'(p + ofb_pkg::HALF_BIAS), t[22:0]};
    end
  endfunction

  // Checks a raw value against the limits of the current output depth.
  function automatic logic in_range(input logic [15:0] v, input logic ten);
    logic [15:0] lo;
    logic [15:0] hi;
    lo = ten ? ofb_pkg::RAW_MIN_10 : ofb_pkg::RAW_MIN_8;
    hi = ten ? ofb_pkg::RAW_MAX_10 : ofb_pkg::RAW_MAX_8;
    in_range = ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
  endfunction

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic taken;
  logic wr_pend;
  logic rd_late;
  ofb_pkg::ofb_addr_type wr_addr;
  ofb_pkg::ofb_addr_type rd_addr;
  ofb_pkg::ofb_addr_type rd_sel;
  logic [31:0] rd_word;
  logic ten_bit;
  logic [ofb_pkg::IRQ_W-1:0] irq_status;
  logic [ofb_pkg::IRQ_W-1:0] irq_mask;
  logic [ofb_pkg::IRQ_W-1:0] irq_clear;
  wire [15:0] bal_raw [ofb_pkg::NUM_BANKS];
  wire [7:0] status_code [ofb_pkg::NUM_BANKS];
  wire [ofb_pkg::NUM_BANKS-1:0] upd_evt;
  wire [ofb_pkg::NUM_BANKS-1:0] rng_evt;
  wire [ofb_pkg::NUM_BANKS-1:0] range_err;

  // ---------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------
  // An address phase is taken on any NONSEQ or SEQ transfer to this slave.
  assign taken = hsel && htrans[1] && hready;

  // Write address phase is held until its data phase one cycle later.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else begin
      wr_pend <= taken && hwrite;
      if (taken && hwrite) begin
        wr_addr <= decode(haddr);
      end
    end
  end

  // A read right behind a write waits one cycle so it sees the new value.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      rd_late <= 1'b0;
      rd_addr <= '0;
    end else if (rd_late) begin
      hrdata <= rd_word;
      hreadyout <= 1'b1;
      rd_late <= 1'b0;
    end else if (taken && !hwrite) begin
      if (wr_pend) begin
        rd_late <= 1'b1;
        hreadyout <= 1'b0;
        rd_addr <= decode(haddr);
      end else begin
        hrdata <= rd_word;
      end
    end
  end

  // Every transfer completes with an OKAY response.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Balance banks
  // ---------------------------------------------------------------
  for (genvar b = 0; b < ofb_pkg::NUM_BANKS; b++) begin : g_bank
    logic [15:0] setting;
    logic err;
    logic hit;
    logic good;
    ofb_pkg::ofb_conv_type conv;

    // Both value fields steer one setting; the float is turned into steps.
    always_comb begin
      hit = wr_pend && wr_addr.bank_hit && (wr_addr.bank == 2'(b))
            && ((wr_addr.field == ofb_pkg::FLD_RAW)
            || (wr_addr.field == ofb_pkg::FLD_ABS));
      conv.ok = 1'b1;
      conv.raw = hwdata[15:0];
      if (wr_addr.field == ofb_pkg::FLD_ABS) begin
        conv = float_to_raw(hwdata);
      end
      good = conv.ok && in_range(conv.raw, ten_bit);
    end

    // A good write updates the setting; a bad one leaves it untouched.
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        setting <= ofb_pkg::RAW_RESET;
      end else if (hit && good) begin
        setting <= conv.raw;
      end
    end

    // The error mark stays until a write lands within the limits.
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        err <= 1'b0;
      end else if (hit) begin
        err <= !good;
      end
    end

    // Status also flags a held value left outside after a depth change.
    assign status_code[b] = !ofb_pkg::BANK_PRESENT[b] ? ofb_pkg::STATUS_NONE :
                            (err || !in_range(setting, ten_bit)) ?
                            ofb_pkg::STATUS_RANGE : ofb_pkg::STATUS_OK;
    assign bal_raw[b] = setting;
    assign range_err[b] = err;
    assign upd_evt[b] = hit && good;
    assign rng_evt[b] = hit && !good;
  end

  // The datapath receives raw half steps; it divides by two itself.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      balance <= '0;
    end else begin
      balance.lr <= bal_raw[0];
      balance.left_oddeven <= bal_raw[1];
      balance.right_oddeven <= bal_raw[2];
    end
  end

  // ---------------------------------------------------------------
  // Output depth and interrupts
  // ---------------------------------------------------------------
  // Selects the 8-bit or 10-bit limits.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ten_bit <= ofb_pkg::MODE_RESET;
    end else if (wr_pend && wr_addr.own_hit && wr_addr.field == ofb_pkg::FLD_MODE) begin
      ten_bit <= hwdata[0];
    end
  end

  // Interrupt mask has the same layout as the status.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= ofb_pkg::IRQ_RESET;
    end else if (wr_pend && wr_addr.own_hit && wr_addr.field == ofb_pkg::FLD_IRQ_MASK) begin
      irq_mask <= hwdata[ofb_pkg::IRQ_W-1:0];
    end
  end

  // Writing a one clears a bit; a new event in the same cycle wins.
  assign irq_clear = (wr_pend && wr_addr.own_hit && wr_addr.field == ofb_pkg::FLD_IRQ_STATUS)
                     ? hwdata[ofb_pkg::IRQ_W-1:0] : ofb_pkg::IRQ_RESET;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= ofb_pkg::IRQ_RESET;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | {rng_evt, upd_evt};
    end
  end

  // Level interrupt from any unmasked status bit.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // ---------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------
  assign rd_sel = rd_late ? rd_addr : decode(haddr);
  // Narrow fields sit in the low bits; unmapped words read zero.
  always_comb begin
    rd_word = 32'h00000000;
    if (rd_sel.bank_hit) begin
      case (rd_sel.field)
        ofb_pkg::FLD_STATUS: rd_word = {24'h000000, status_code[rd_sel.bank]};
        ofb_pkg::FLD_ABS: rd_word = raw_to_float(bal_raw[rd_sel.bank]);
        ofb_pkg::FLD_ABS_MIN: rd_word = ten_bit ? ofb_pkg::ABS_MIN_10 : ofb_pkg::ABS_MIN_8;
        ofb_pkg::FLD_ABS_MAX: rd_word = ten_bit ? ofb_pkg::ABS_MAX_10 : ofb_pkg::ABS_MAX_8;
        ofb_pkg::FLD_RAW: rd_word = {16'h0000, bal_raw[rd_sel.bank]};
        ofb_pkg::FLD_RAW_MIN: rd_word = {16'h0000,
          ten_bit ? ofb_pkg::RAW_MIN_10 : ofb_pkg::RAW_MIN_8};
        ofb_pkg::FLD_RAW_MAX: rd_word = {16'h0000,
          ten_bit ? ofb_pkg::RAW_MAX_10 : ofb_pkg::RAW_MAX_8};
        default: rd_word = 32'h00000000;
      endcase
    end else if (rd_sel.own_hit) begin
      case (rd_sel.field)
        ofb_pkg::FLD_MODE: rd_word = {31'h00000000, ten_bit};
        ofb_pkg::FLD_IRQ_STATUS: rd_word = {26'h0000000, irq_status};
        ofb_pkg::FLD_IRQ_MASK: rd_word = {26'h0000000, irq_mask};
        default: rd_word = 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_lr_raw;
  logic wr_loe_raw;
  logic wr_roe_raw;
  logic wr_lr_abs;
  assign rd_lr_raw = taken && !hwrite && !wr_pend
                     && haddr == ofb_pkg::reg_addr(ofb_pkg::LR_BASE, ofb_pkg::FLD_RAW);
  assign wr_loe_raw = g_bank[1].hit && wr_addr.field == ofb_pkg::FLD_RAW;
  assign wr_roe_raw = g_bank[2].hit && wr_addr.field == ofb_pkg::FLD_RAW;
  assign wr_lr_abs = g_bank[0].hit && wr_addr.field == ofb_pkg::FLD_ABS;

  // A raw read of the first bank returns its setting, high half zero.
  property p_lr_map;
    rd_lr_raw |=> hrdata == {16'h0000, $past(bal_raw[0])};
  endproperty
  a_lr_map: assert property (p_lr_map) else $error("left/right raw readback wrong");

  // A good raw write to the left odd/even bank lands in that bank and leaves the left/right bank unchanged.
  property p_loe_write;
    (wr_loe_raw && g_bank[1].good) |=> bal_raw[1] == $past(hwdata[15:0])
      && $stable(bal_raw[0]);
  endproperty
  a_loe_write: assert property (p_loe_write) else $error("left odd/even write lost");

  // A good raw write to the right bank reaches the datapath two edges on.
  property p_roe_out;
    (wr_roe_raw && g_bank[2].good) |=> ##1 balance.right_oddeven == $past(hwdata[15:0], 2);
  endproperty
  a_roe_out: assert property (p_roe_out) else $error("right odd/even output stale");

  // Status of the left/right bank is only ever the good or the range code.
  property p_status_codes;
    status_code[0] == ofb_pkg::STATUS_OK || status_code[0] == ofb_pkg::STATUS_RANGE;
  endproperty
  a_status_codes: assert property (p_status_codes) else $error("illegal status code");

  // A refused write shows the range code from the next cycle.
  property p_bad_write;
    g_bank[0].hit && !g_bank[0].good |=> status_code[0] == ofb_pkg::STATUS_RANGE
      && $stable(bal_raw[0]);
  endproperty
  a_bad_write: assert property (p_bad_write) else $error("range error not shown");

  // A good float write other than negative zero reads back as the same float word.
  property p_abs_echo;
    (wr_lr_abs && g_bank[0].good && hwdata != 32'h80000000)
      |=> raw_to_float(bal_raw[0]) == $past(hwdata);
  endproperty
  a_abs_echo: assert property (p_abs_echo) else $error("float readback differs");

  // In 8-bit mode a left/right setting accepted by a write stays within 40 steps.
  property p_range_8;
    (!ten_bit && g_bank[0].hit && g_bank[0].good)
      |=> $signed(bal_raw[0]) >= -40 && $signed(bal_raw[0]) <= 40;
  endproperty
  a_range_8: assert property (p_range_8) else $error("8-bit limit broken");

  // The left odd/even setting never leaves the 10-bit limits.
  property p_range_10;
    $signed(bal_raw[1]) >= -160 && $signed(bal_raw[1]) <= 160;
  endproperty
  a_range_10: assert property (p_range_10) else $error("10-bit limit broken");

  // The error mark holds for as long as no write reaches the bank.
  property p_err_hold;
    (range_err[0] && !g_bank[0].hit) |=> range_err[0];
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("range error dropped");

  // In 8-bit mode the raw minimum word reads the 8-bit limit.
  property p_limits;
    (taken && !hwrite && !wr_pend && !ten_bit
      && haddr == ofb_pkg::reg_addr(ofb_pkg::LR_BASE, ofb_pkg::FLD_RAW_MIN))
      |=> hrdata == {16'h0000, ofb_pkg::RAW_MIN_8};
  endproperty
  a_limits: assert property (p_limits) else $error("raw minimum wrong");
  c_bad_write: cover property (g_bank[0].hit && !g_bank[0].good);
  c_abs_write: cover property (wr_lr_abs && g_bank[0].good);
  c_irq_rise: cover property (!irq ##1 irq);
  c_late_read: cover property (rd_late);
endmodule

// [testbench/ofb_regs_tb_top.sv]
// Self-checking testbench for the offset-balance register bank.
`timescale 1ns/1ps

module ofb_regs_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irq;
  ofb_pkg::ofb_balance_type balance;
  int num_errors = 0;
  int n_tests = 0;
  int seed = 32'h9EAF;
  int cycles = 0;
  logic [11:0] bases [3] = '{ofb_pkg::LR_BASE, ofb_pkg::LEFT_OE_BASE, ofb_pkg::RIGHT_OE_BASE};
  logic [31:0] rd;

  // ---------------------------------------------------------------
  // Clock, bus wiring and design
  // ---------------------------------------------------------------
  // The single slave's ready is the bus ready.
  always #2 hclk = ~hclk;
  assign hready = hreadyout;

  ofb_regs uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .balance(balance)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Compares one value and counts the comparison.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the verdict and stops the run.
  task automatic end_of_test();
    if (num_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Byte address of a field: four times the register index.
  function automatic logic [31:0] adr(input logic [11:0] base, input logic [4:0] fld);
    logic [11:0] idx;
    idx = base + {7'h00, fld};
    return {18'h00000, idx, 2'h0};
  endfunction

  // Single-precision bits of half a raw count.
  function automatic logic [31:0] half_float(input int r);
    int m;
    int p;
    m = (r < 0) ? -r : r;
    if (m == 0) return 32'h00000000;
    p = 0;
    while ((m >> (p + 1)) != 0) p++;
    return {(r < 0), 8'(p + 126), 23'((m << (23 - p)) & 32'h007FFFFF)};
  endfunction

  // One single transfer: address phase, then data phase.
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    d = hrdata;
  endtask

  // Write, with the read's address phase overlapping the write's data phase.
  task automatic wr_rd(input logic [31:0] a, input logic [31:0] wd, output logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    do @(posedge hclk); while (hready !== 1'b1);
    hwrite <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    do @(posedge hclk); while (hready !== 1'b1);
    d = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(a, 1'b1, d, x);
  endtask

  task automatic rdc(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] x;
    xfer(a, 1'b0, 32'h00000000, x);
    chk(what, x, exp);
  endtask

  // Reads back raw, float and status of a bank and checks the applied balance.
  task automatic bank_chk(input int b, input logic [15:0] r, input logic [7:0] st);
    logic [15:0] bal;
    rdc("raw", adr(bases[b], ofb_pkg::FLD_RAW), {16'h0000, r});
    rdc("absolute", adr(bases[b], ofb_pkg::FLD_ABS), half_float($signed(r)));
    rdc("status", adr(bases[b], ofb_pkg::FLD_STATUS), {24'h000000, st});
    bal = (b == 0) ? balance.lr : (b == 1) ? balance.left_oddeven : balance.right_oddeven;
    chk("balance", {16'h0000, bal}, {16'h0000, r});
  endtask

  // Checks the four limit fields for a raw bound of lim.
  task automatic lim_chk(input int b, input int lim);
    rdc("abs min", adr(bases[b], ofb_pkg::FLD_ABS_MIN), half_float(-lim));
    rdc("abs max", adr(bases[b], ofb_pkg::FLD_ABS_MAX), half_float(lim));
    rdc("raw min", adr(bases[b], ofb_pkg::FLD_RAW_MIN), {16'h0000, 16'(-lim)});
    rdc("raw max", adr(bases[b], ofb_pkg::FLD_RAW_MAX), {16'h0000, 16'(lim)});
  endtask

  // Cuts a hang short and closes the run.
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  // Reset, fixed corner cases, then random traffic.
  initial begin
    int r;
    int b;
    int lim;
    repeat (10) @(posedge hclk);
    chk("reset outputs", {13'h0000, hreadyout, irq, hresp, balance[15:0]}, 32'h00040000);
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (b = 0; b < 3; b++) begin
      wr(adr(bases[b], ofb_pkg::FLD_ABS_MIN), 32'h00000000);
      wr(adr(bases[b], ofb_pkg::FLD_STATUS), 32'h00000080);
      lim_chk(b, 40);
      bank_chk(b, 16'h0000, 8'h01);
    end
    rdc("unmapped", 32'h00000100, 32'h00000000);
    rdc("unmapped field", adr(ofb_pkg::LR_BASE, 5'h13), 32'h00000000);
    // Good write raises bit 0, masked until the mask opens it.
    wr(adr(ofb_pkg::LR_BASE, ofb_pkg::FLD_RAW), 32'h0000000F);
    chk("irq masked", {31'h0, irq}, 32'h00000000);
    rdc("irq status", adr(ofb_pkg::OWN_BASE, ofb_pkg::FLD_IRQ_STATUS), 32'h00000001);
    wr(adr(ofb_pkg::OWN_BASE, ofb_pkg::FLD_IRQ_MASK), 32'h00000001);
    repeat (2) @(posedge hclk);
    chk("irq set", {31'h0, irq}, 32'h00000001);
    wr(adr(ofb_pkg::OWN_BASE, ofb_pkg::FLD_IRQ_STATUS), 32'h00000001);
    repeat (2) @(posedge hclk);
    chk("irq cleared", {31'h0, irq}, 32'h00000000);
    bank_chk(0, 16'h000F, 8'h01);
    // Refused write on the right odd/even bank raises bit 5.
    wr(adr(ofb_pkg::RIGHT_OE_BASE, ofb_pkg::FLD_RAW), 32'h00000029);
    rdc("irq refused", adr(ofb_pkg::OWN_BASE, ofb_pkg::FLD_IRQ_STATUS), 32'h00000020);
    wr(adr(ofb_pkg::OWN_BASE, ofb_pkg::FLD_IRQ_MASK), 32'h00000020);
    repeat (2) @(posedge hclk);
    chk("irq refused out", {31'h0, irq}, 32'h00000001);
    wr(adr(ofb_pkg::OWN_BASE, ofb_pkg::FLD_IRQ_STATUS), 32'h0000003F);
    wr(adr(ofb_pkg::OWN_BASE, ofb_pkg::FLD_IRQ_MASK), 32'h00000000);
    // Range boundaries in both output modes, through both fields.
    for (int m = 0; m < 2; m++) begin
      lim = (m == 1) ? 160 : 40;
      wr(adr(ofb_pkg::OWN_BASE, ofb_pkg::FLD_MODE), 32'(m));
      for (b = 0; b < 3; b++) begin
        lim_chk(b, lim);
        wr(adr(bases[b], ofb_pkg::FLD_RAW), 32'(lim));
        bank_chk(b, 16'(lim), 8'h01);
        wr(adr(bases[b], ofb_pkg::FLD_RAW), 32'(16'(lim + 1)));
        bank_chk(b, 16'(lim), 8'h80);
        wr(adr(bases[b], ofb_pkg::FLD_ABS), half_float(-lim));
        bank_chk(b, 16'(-lim), 8'h01);
        wr(adr(bases[b], ofb_pkg::FLD_ABS), 32'h3E800000);
        bank_chk(b, 16'(-lim), 8'h80);
      end
    end
    // Back to 8-bit limits while holding -80.0: out of range until rewritten.
    wr(adr(ofb_pkg::OWN_BASE, ofb_pkg::FLD_MODE), 32'h00000000);
    bank_chk(1, 16'hFF60, 8'h80);
    wr(adr(bases[1], ofb_pkg::FLD_RAW), 32'h00000000);
    bank_chk(1, 16'h0000, 8'h01);
    // Random settings through either field, some back to back with a read.
    for (int i = 0; i < 40; i++) begin
      b = $unsigned($random(seed)) % 3;
      r = $random(seed) % 41;
      if (i % 4 == 3) begin
        wr_rd(adr(bases[b], ofb_pkg::FLD_RAW), {16'h0000, 16'(r)}, rd);
        chk("raw back to back", rd, {16'h0000, 16'(r)});
      end else if ($random(seed) & 1) begin
        wr(adr(bases[b], ofb_pkg::FLD_ABS), half_float(r));
      end else begin
        wr(adr(bases[b], ofb_pkg::FLD_RAW), {16'h0000, 16'(r)});
      end
      bank_chk(b, 16'(r), 8'h01);
    end
    chk("irq idle", {31'h0, irq}, 32'h00000000);
    end_of_test();
  end
endmodule
